// file: src/sgc_global_regs.sv
// Switch global control register bank with its configuration consumers.
// Notes on behaviour
// R1 - VLAN enable bit turns on 802.1Q handling.
// R2 - Snoop bit sends IGMP packets to uplink.
// R3 - Scheduling field selects strict or weighted ratio.
// R4 - Sniff bit demands both ports match.
// R5 - Uplink duplex bit: one means half duplex.
// R6 - Uplink flow control bit enables pause.
// R7 - Uplink speed bit: one means 10 Mbps.
// R8 - Uplink duplex, flow, speed loaded from straps.
// R9 - Null VID replaced by port VID.
// R10 - Eleven-bit storm threshold across two registers.
// R11 - Storm period 500 or 67 ms.
// R12 - Power save bit enables PHY power save.
// R13 - Software keeps test mode bit at zero.
// R14 - Register drives low LED select only.
// R15 - LED selects map per-port indicator functions.
// R16 - Factory and scratch registers plain storage.
`timescale 1ns/1ps
`default_nettype none
module sgc_global_regs #(
  parameter int NPORTS = 3,
  parameter int unsigned STORM_CYC_10M_P = sgc_pkg::STORM_CYC_10M,
  parameter int unsigned STORM_CYC_100M_P = sgc_pkg::STORM_CYC_100M
) (
  input wire logic i_sys_clk,                          // System clock, 100 MHz.
  input wire logic i_rst_b,                            // Synchronous reset, active low.
  input wire logic [7:0] i_reg_addr,                   // Register offset.
  input wire logic i_reg_wr_en,                        // Write strobe.
  input wire logic [7:0] i_reg_wdata,                  // Write data.
  input wire logic i_reg_rd_en,                        // Read strobe.
  output logic [7:0] o_reg_rdata,                      // Read data.
  output logic o_reg_rd_valid,                         // Read data valid pulse.
  input wire logic i_speed_strap_pin,                  // Uplink speed strap.
  input wire logic i_duplex_strap_pin,                 // Uplink duplex strap.
  input wire logic i_flowctl_strap_pin,                // Uplink flow control strap.
  input wire logic i_led_select_low,                   // Low LED select strap.
  input wire logic i_led_select_high,                  // High LED select strap.
  input wire logic i_pkt_valid,                        // Packet descriptor valid.
  input wire logic i_pkt_is_igmp,                      // Packet is IGMP.
  input wire logic [11:0] i_pkt_vid,                   // Packet VLAN ID.
  input wire logic [11:0] i_port_vid,                  // Ingress port VID.
  input wire logic i_sniff_src_match,                  // Source port monitored.
  input wire logic i_sniff_dst_match,                  // Destination port monitored.
  output logic o_pkt_valid,                            // Packet result valid.
  output logic o_igmp_to_mii,                          // Forward copy to uplink.
  output logic o_monitored,                            // Packet goes to sniffer.
  output logic [11:0] o_vid_out,                       // VID after replacement.
  input wire logic [NPORTS-1:0] i_storm_block,         // One 64-byte block seen.
  output logic [NPORTS-1:0] o_storm_limit,             // Port over threshold.
  output logic o_storm_period_tick,                    // Period boundary pulse.
  input wire logic [NPORTS-1:0] i_link,                // Port link up.
  input wire logic [NPORTS-1:0] i_act,                 // Port activity.
  input wire logic [NPORTS-1:0] i_full_dpx,            // Port full duplex.
  input wire logic [NPORTS-1:0] i_col,                 // Port collision.
  input wire logic [NPORTS-1:0] i_speed_100,           // Port at 100 Mbps.
  output logic [NPORTS-1:0] o_port_indicator_0,        // Indicator 0 per port.
  output logic [NPORTS-1:0] o_port_indicator_1,        // Indicator 1 per port.
  output logic [NPORTS-1:0] o_port_indicator_2,        // Indicator 2 per port.
  output logic o_vlan_en,                              // 802.1Q mode on.
  output logic o_igmp_snoop_en,                        // IGMP snooping on.
  output logic [3:0] o_sched_high_weight,              // High per low, 0 strict.
  output logic o_sniff_and_mode,                       // Both ports must match.
  output logic o_mii_half_duplex,                      // Uplink half duplex.
  output logic o_mii_flowctl_en,                       // Uplink flow control.
  output logic o_mii_speed_10,                         // Uplink at 10 Mbps.
  output logic o_null_vid_replace,                     // Null VID replace on.
  output logic [sgc_pkg::STORM_THR_W-1:0] o_storm_threshold, // Blocks per period.
  output logic o_phy_power_save,                       // PHY power save.
  output logic o_factory_test_mode,                    // Test mode bit.
  output logic o_special_tpid,                         // Special TPID mode.
  output logic o_led_sel_low,                          // Low LED select.
  output logic o_led_sel_high                          // High LED select.
);
  import sgc_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
    return en && (a == ofs);
  endfunction
  function automatic logic [3:0] sched_weight(input logic [1:0] f);
    logic [3:0] w;
    w = SCHED_W_STRICT;
    unique case (f)
      2'b00: w = SCHED_W_STRICT;
      2'b01: w = SCHED_W_10;
      2'b10: w = SCHED_W_5;
      2'b11: w = SCHED_W_2;
    endcase
    return w;
  endfunction
  // Returns {indicator 2, indicator 1, indicator 0}.
  function automatic logic [2:0] led_map(input logic [1:0] sel, input logic link,
                                         input logic act, input logic fdx,
                                         input logic col, input logic s100);
    logic [2:0] m;
    m = 3'h0;
    unique case (sel)
      2'b01: m = {link & s100 & ~act, link & ~s100 & ~act, fdx};
      2'b10: m = {act, link, fdx | col};
      default: m = {link & ~act, fdx | col, s100};
    endcase
    return m;
  endfunction

  // ------------------------------------------------------------
  // Strap synchronisers
  // ------------------------------------------------------------
  logic [4:0] strap_s1;
  logic [4:0] strap_s2;
  always_ff @(posedge i_sys_clk) begin
    strap_s1 <= {i_led_select_high, i_led_select_low, i_flowctl_strap_pin,
                 i_duplex_strap_pin, i_speed_strap_pin};
    strap_s2 <= strap_s1;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] vlan_sched_r;
  logic [7:0] uplink_r;
  logic [7:0] storm_low_r;
  logic [7:0] factory_a_r;
  logic [7:0] factory_b_r;
  logic [7:0] factory_c_r;
  logic [7:0] power_led_r;
  logic [7:0] scratch_one_r;
  logic [7:0] scratch_two_r;
  logic led_high_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      vlan_sched_r <= RST_VLAN_SCHED;
    end else if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_VLAN_SCHED)) begin
      vlan_sched_r <= i_reg_wdata; // R1 R2 R3 R4
    end
  end
  // Straps are reloaded on every clock edge while reset is held, so the value at release wins.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      uplink_r <= RST_UPLINK_STORM_HI;
      uplink_r[US_HALF_BIT] <= strap_s2[1]; // R8
      uplink_r[US_FLOW_BIT] <= strap_s2[2]; // R8
      uplink_r[US_10M_BIT] <= strap_s2[0]; // R8
    end else if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_UPLINK_STORM_HI)) begin
      uplink_r <= i_reg_wdata; // R5 R6 R7 R9 R10
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      storm_low_r <= RST_STORM_LOW;
    end else if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_STORM_LOW)) begin
      storm_low_r <= i_reg_wdata; // R10
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      factory_a_r <= RST_FACTORY_A;
      factory_b_r <= RST_FACTORY_B;
      factory_c_r <= RST_FACTORY_C;
      scratch_one_r <= RST_SCRATCH;
      scratch_two_r <= RST_SCRATCH;
    end else begin
      if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_FACTORY_A)) begin
        factory_a_r <= i_reg_wdata; // R16
      end
      if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_FACTORY_B)) begin
        factory_b_r <= i_reg_wdata; // R16
      end
      if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_FACTORY_C)) begin
        factory_c_r <= i_reg_wdata; // R16
      end
      if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_SCRATCH_ONE)) begin
        scratch_one_r <= i_reg_wdata; // R16
      end
      if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_SCRATCH_TWO)) begin
        scratch_two_r <= i_reg_wdata; // R16
      end
    end
  end
  // Bit 7 has no storage and reads zero.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      power_led_r <= RST_POWER_LED;
      power_led_r[PL_LEDSEL_BIT] <= strap_s2[3]; // R14
      led_high_r <= strap_s2[4]; // R14
    end else if (wr_hit(i_reg_wr_en, i_reg_addr, OFS_POWER_LED)) begin
      power_led_r <= {1'b0, i_reg_wdata[6:0]}; // R12 R14
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_reg_addr)
      OFS_VLAN_SCHED: rd_mux = vlan_sched_r;
      OFS_UPLINK_STORM_HI: rd_mux = uplink_r;
      OFS_STORM_LOW: rd_mux = storm_low_r;
      OFS_FACTORY_A: rd_mux = factory_a_r;
      OFS_FACTORY_B: rd_mux = factory_b_r;
      OFS_FACTORY_C: rd_mux = factory_c_r;
      OFS_POWER_LED: rd_mux = power_led_r;
      OFS_RESERVED: rd_mux = RST_RESERVED; // R16
      OFS_SCRATCH_ONE: rd_mux = scratch_one_r;
      OFS_SCRATCH_TWO: rd_mux = scratch_two_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd_en;
      if (i_reg_rd_en) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  assign o_vlan_en = vlan_sched_r[VS_VLAN_BIT]; // R1
  assign o_igmp_snoop_en = vlan_sched_r[VS_SNOOP_BIT];
  assign o_sniff_and_mode = vlan_sched_r[VS_SNIFF_BIT];
  assign o_mii_half_duplex = uplink_r[US_HALF_BIT]; // R5
  assign o_mii_flowctl_en = uplink_r[US_FLOW_BIT]; // R6
  assign o_mii_speed_10 = uplink_r[US_10M_BIT]; // R7
  assign o_null_vid_replace = uplink_r[US_NULLVID_BIT];
  assign o_storm_threshold = {uplink_r[2:0], storm_low_r}; // R10
  assign o_phy_power_save = power_led_r[PL_PWRSAVE_BIT]; // R12
  assign o_factory_test_mode = power_led_r[PL_TEST_BIT]; // R13
  assign o_special_tpid = power_led_r[PL_TPID_BIT];
  assign o_led_sel_low = power_led_r[PL_LEDSEL_BIT]; // R14
  assign o_led_sel_high = led_high_r; // R14

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_sched_high_weight <= SCHED_W_STRICT;
    end else begin
      o_sched_high_weight <= sched_weight(vlan_sched_r[VS_SCHED_LSB +: 2]); // R3
    end
  end

  // ------------------------------------------------------------
  // Per-packet decisions
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pkt_valid <= 1'b0;
      o_igmp_to_mii <= 1'b0;
      o_monitored <= 1'b0;
      o_vid_out <= NULL_VID;
    end else begin
      o_pkt_valid <= i_pkt_valid;
      if (i_pkt_valid) begin
        o_igmp_to_mii <= o_igmp_snoop_en && i_pkt_is_igmp; // R2
        if (o_sniff_and_mode) begin
          o_monitored <= i_sniff_src_match && i_sniff_dst_match; // R4
        end else begin
          o_monitored <= i_sniff_src_match || i_sniff_dst_match; // R4
        end
        if (o_null_vid_replace && (i_pkt_vid == NULL_VID)) begin
          o_vid_out <= i_port_vid; // R9
        end else begin
          o_vid_out <= i_pkt_vid;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Broadcast storm metering
  // ------------------------------------------------------------
  sgc_period_if pif ();
  assign pif.speed_10 = o_mii_speed_10;
  sgc_storm_timer #(
    .CYC_10M(STORM_CYC_10M_P),
    .CYC_100M(STORM_CYC_100M_P)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .pif(pif.tmr)
  );
  assign o_storm_period_tick = pif.tick; // R11
  logic [STORM_THR_W-1:0] storm_cnt_r [NPORTS];
  // Counters saturate, and the period boundary starts every port afresh.
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < NPORTS; p++) begin
      if (!i_rst_b || pif.tick) begin
        storm_cnt_r[p] <= '0; // R11
        o_storm_limit[p] <= 1'b0;
      end else if (i_storm_block[p] && (storm_cnt_r[p] != '1)) begin
        storm_cnt_r[p] <= storm_cnt_r[p] + 1'b1;
        o_storm_limit[p] <= ((storm_cnt_r[p] + 1'b1) > o_storm_threshold); // R10
      end
    end
  end

  // ------------------------------------------------------------
  // Port indicators
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < NPORTS; p++) begin
      if (!i_rst_b) begin
        {o_port_indicator_2[p], o_port_indicator_1[p], o_port_indicator_0[p]} <= 3'h0;
      end else begin
        {o_port_indicator_2[p], o_port_indicator_1[p], o_port_indicator_0[p]} <=
          led_map({led_high_r, o_led_sel_low}, i_link[p], i_act[p], i_full_dpx[p],
                  i_col[p], i_speed_100[p]); // R15
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  vlan_enable_a: assert property ( // R1
    wr_hit(i_reg_wr_en, i_reg_addr, OFS_VLAN_SCHED) |=> o_vlan_en == $past(i_reg_wdata[7]))
    else $error("VLAN enable did not follow write.");
  igmp_forward_a: assert property ( // R2
    i_pkt_valid |=> o_igmp_to_mii == ($past(i_pkt_is_igmp) && $past(o_igmp_snoop_en)))
    else $error("IGMP forward decision wrong.");
  sched_ratio_a: assert property ( // R3
    vlan_sched_r[3:2] == 2'b01 |=> o_sched_high_weight == 4'ha)
    else $error("Scheduling weight wrong for 10 to 1.");
  sniff_and_a: assert property ( // R4
    i_pkt_valid && o_sniff_and_mode && !i_sniff_dst_match |=> !o_monitored)
    else $error("AND sniff marked a half match.");
  sniff_or_a: assert property ( // R4
    i_pkt_valid && !o_sniff_and_mode && i_sniff_src_match |=> o_monitored)
    else $error("OR sniff missed a source match.");
  uplink_mode_a: assert property ( // R5
    wr_hit(i_reg_wr_en, i_reg_addr, OFS_UPLINK_STORM_HI) |=>
      {o_mii_half_duplex, o_mii_flowctl_en, o_mii_speed_10} == $past(i_reg_wdata[6:4]))
    else $error("Uplink mode bits did not follow write.");
  strap_load_a: assert property ( // R8
    $rose(i_rst_b) |-> o_mii_speed_10 == $past(strap_s2[0], 1) &&
      o_mii_half_duplex == $past(strap_s2[1], 1))
    else $error("Uplink straps not loaded at reset.");
  null_vid_a: assert property ( // R9
    i_pkt_valid && o_null_vid_replace && i_pkt_vid == 12'h000 |=>
      o_vid_out == $past(i_port_vid))
    else $error("Null VID not replaced.");
  storm_period_a: assert property ( // R11
    o_storm_period_tick |=> storm_cnt_r[0] == '0 && !o_storm_limit[0])
    else $error("Storm count survived period end.");
  power_save_a: assert property ( // R12
    wr_hit(i_reg_wr_en, i_reg_addr, OFS_POWER_LED) |=>
      o_phy_power_save == $past(i_reg_wdata[6]) && $stable(o_led_sel_high))
    else $error("Power save or LED select wrong after write.");
  reserved_read_a: assert property ( // R16
    i_reg_rd_en && i_reg_addr == OFS_RESERVED |=> o_reg_rd_valid && o_reg_rdata == 8'h00)
    else $error("Reserved register read non-zero.");
endmodule
`default_nettype wire

// file: pkg/sgc_pkg.sv
// Constants and field layout of the switch global control register bank.
package sgc_pkg;

  // ------------------------------------------------------------
  // Clock and storm period timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned STORM_PERIOD_10M_MS = 500;
  localparam int unsigned STORM_PERIOD_100M_MS = 67;
  localparam int unsigned STORM_CYC_10M = STORM_PERIOD_10M_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned STORM_CYC_100M = STORM_PERIOD_100M_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_VLAN_SCHED = 8'h05;
  localparam logic [7:0] OFS_UPLINK_STORM_HI = 8'h06;
  localparam logic [7:0] OFS_STORM_LOW = 8'h07;
  localparam logic [7:0] OFS_FACTORY_A = 8'h08;
  localparam logic [7:0] OFS_FACTORY_B = 8'h09;
  localparam logic [7:0] OFS_FACTORY_C = 8'h0a;
  localparam logic [7:0] OFS_POWER_LED = 8'h0b;
  localparam logic [7:0] OFS_RESERVED = 8'h0c;
  localparam logic [7:0] OFS_SCRATCH_ONE = 8'h0d;
  localparam logic [7:0] OFS_SCRATCH_TWO = 8'h0e;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int VS_VLAN_BIT = 7;
  localparam int VS_SNOOP_BIT = 6;
  localparam int VS_SCHED_LSB = 2;
  localparam int VS_SNIFF_BIT = 0;
  localparam int US_HALF_BIT = 6;
  localparam int US_FLOW_BIT = 5;
  localparam int US_10M_BIT = 4;
  localparam int US_NULLVID_BIT = 3;
  localparam int PL_RSVD_BIT = 7;
  localparam int PL_PWRSAVE_BIT = 6;
  localparam int PL_TEST_BIT = 4;
  localparam int PL_LEDSEL_BIT = 1;
  localparam int PL_TPID_BIT = 0;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [7:0] RST_VLAN_SCHED = 8'h00;
  localparam logic [7:0] RST_UPLINK_STORM_HI = 8'h00;
  localparam logic [7:0] RST_STORM_LOW = 8'h63;
  localparam logic [7:0] RST_FACTORY_A = 8'h4e;
  localparam logic [7:0] RST_FACTORY_B = 8'h24;
  localparam logic [7:0] RST_FACTORY_C = 8'h24;
  localparam logic [7:0] RST_POWER_LED = 8'h08;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;

  // ------------------------------------------------------------
  // Scheduling weights and widths
  // ------------------------------------------------------------
  localparam logic [3:0] SCHED_W_STRICT = 4'h0;
  localparam logic [3:0] SCHED_W_10 = 4'ha;
  localparam logic [3:0] SCHED_W_5 = 4'h5;
  localparam logic [3:0] SCHED_W_2 = 4'h2;
  localparam int STORM_THR_W = 11;
  localparam logic [11:0] NULL_VID = 12'h000;

endpackage

// file: pkg/sgc_period_if.sv
// Handshake between the register bank and its storm period timer.
`timescale 1ns/1ps
`default_nettype none
interface sgc_period_if;
  logic speed_10;
  logic tick;
  modport ctl (output speed_10, input tick);
  modport tmr (input speed_10, output tick);
endinterface
`default_nettype wire

// file: src/sgc_storm_timer.sv
// Free running storm measurement period timer.
`timescale 1ns/1ps
`default_nettype none
module sgc_storm_timer #(
  parameter int unsigned CYC_10M = 500,
  parameter int unsigned CYC_100M = 67
) (
  input wire logic i_sys_clk,  // System clock.
  input wire logic i_rst_b,    // Synchronous reset, active low.
  sgc_period_if.tmr pif        // Speed in, period tick out.
);

  logic [31:0] cnt_r;
  logic speed_q_r;
  logic tick_r;
  logic [31:0] limit;
  logic wrap;

  assign limit = pif.speed_10 ? 32'(CYC_10M - 1) : 32'(CYC_100M - 1);
  assign wrap = (cnt_r >= limit);

  // A speed change restarts the period so no short window is measured.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_r <= 32'h0;
      speed_q_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      speed_q_r <= pif.speed_10;
      if (speed_q_r != pif.speed_10) begin
        cnt_r <= 32'h0;
        tick_r <= 1'b0;
      end else if (wrap) begin
        cnt_r <= 32'h0;
        tick_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'h1;
        tick_r <= 1'b0;
      end
    end
  end

  assign pif.tick = tick_r;

endmodule
`default_nettype wire

// file: dv/test_sgc_global_regs.sv
// Self-checking bench for the switch global control register bank.
`timescale 1ns/1ps
`default_nettype none
module test_sgc_global_regs;
  import sgc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic pkt_v = 1'b0;
  logic igmp = 1'b0;
  logic src = 1'b0;
  logic dst = 1'b0;
  logic [4:0] st = 5'h16;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [11:0] vid = 12'h000;
  logic [11:0] pvid = 12'h123;
  logic [2:0] blk = 3'h0;
  logic [2:0] lnk = 3'h7;
  logic [2:0] act = 3'h0;
  logic [2:0] fdx = 3'h3;
  logic [2:0] col = 3'h0;
  logic [2:0] s100 = 3'h5;
  logic [7:0] rdata;
  logic [11:0] vid_o;
  logic [10:0] thr;
  logic [3:0] wgt;
  logic [2:0] lim;
  logic [2:0] ind0, ind1, ind2;
  logic tmode, tpid;
  logic rv, pv, igmp_o, mon, tick, vlan, snoop, sniff, half, flow, spd10, nrep, pwr, sl, sh;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  logic [7:0] rexp [10] = '{8'h00, 8'h50, 8'h63, 8'h4e, 8'h24, 8'h24, 8'h0a, 8'h00, 8'h00, 8'h00};
  logic [3:0] wexp [4] = '{4'h0, 4'ha, 4'h5, 4'h2};

  sgc_global_regs #(.STORM_CYC_10M_P(50), .STORM_CYC_100M_P(20)) DUT (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr_en(wr_en),
    .i_reg_wdata(wdata), .i_reg_rd_en(rd_en), .o_reg_rdata(rdata), .o_reg_rd_valid(rv),
    .i_speed_strap_pin(st[2]), .i_duplex_strap_pin(st[4]), .i_flowctl_strap_pin(st[3]),
    .i_led_select_low(st[1]), .i_led_select_high(st[0]), .i_pkt_valid(pkt_v),
    .i_pkt_is_igmp(igmp), .i_pkt_vid(vid), .i_port_vid(pvid), .i_sniff_src_match(src),
    .i_sniff_dst_match(dst), .o_pkt_valid(pv), .o_igmp_to_mii(igmp_o), .o_monitored(mon),
    .o_vid_out(vid_o), .i_storm_block(blk), .o_storm_limit(lim), .o_storm_period_tick(tick),
    .i_link(lnk), .i_act(act), .i_full_dpx(fdx), .i_col(col), .i_speed_100(s100),
    .o_port_indicator_0(ind0), .o_port_indicator_1(ind1), .o_port_indicator_2(ind2),
    .o_vlan_en(vlan), .o_igmp_snoop_en(snoop), .o_sched_high_weight(wgt),
    .o_sniff_and_mode(sniff), .o_mii_half_duplex(half), .o_mii_flowctl_en(flow),
    .o_mii_speed_10(spd10), .o_null_vid_replace(nrep), .o_storm_threshold(thr),
    .o_phy_power_save(pwr), .o_factory_test_mode(tmode), .o_special_tpid(tpid),
    .o_led_sel_low(sl), .o_led_sel_high(sh));

  always #5 clk = ~clk;

  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reset(input logic [4:0] s);
    @(negedge clk);
    st = s;
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk(16'(rv), 16'h1);
    chk(16'(rdata), 16'(e));
  endtask

  task automatic pkt(input logic g, input logic [11:0] v, input logic s, input logic d);
    @(negedge clk);
    igmp = g;
    vid = v;
    src = s;
    dst = d;
    pkt_v = 1'b1;
    @(negedge clk);
    pkt_v = 1'b0;
    chk(16'(pv), 16'h1);
  endtask

  task automatic wait_tick;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 200);
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    print_verdict;
  end

  initial begin
    reset(5'h16);
    for (int i = 0; i < 10; i++) rd(8'h05 + 8'(i), rexp[i]);
    rd(8'h20, 8'h00);
    chk(16'({half, flow, spd10, sl, sh}), 16'h16);
    chk(16'(thr), 16'h063);
    chk(16'({ind2, ind1, ind0}), 16'h153);
    wr(8'h0d, 8'ha5);
    wr(8'h0e, 8'h5a);
    wr(8'h08, 8'hff);
    wr(8'h0c, 8'h77);
    rd(8'h0d, 8'ha5);
    rd(8'h0e, 8'h5a);
    rd(8'h08, 8'hff);
    rd(8'h0c, 8'h00);
    pkt(1'b1, 12'h000, 1'b1, 1'b0);
    chk(16'({igmp_o, mon, vlan}), 16'h2);
    chk(16'(vid_o), 16'h000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h05, {2'b11, 2'b00, 2'(i), 2'b01});
      @(negedge clk);
      chk(16'(wgt), 16'(wexp[i]));
      chk(16'({vlan, snoop, sniff}), 16'h7);
    end
    pkt(1'b1, 12'h000, 1'b1, 1'b0);
    chk(16'({igmp_o, mon}), 16'h2);
    wr(8'h06, 8'h78);
    chk(16'({half, flow, spd10, nrep}), 16'hf);
    pkt(1'b0, 12'h000, 1'b1, 1'b1);
    chk(16'({igmp_o, mon, vid_o}), 16'h1123);
    pkt(1'b0, 12'h456, 1'b0, 1'b1);
    chk(16'(vid_o), 16'h456);
    wr(8'h06, 8'h10);
    wr(8'h07, 8'h01);
    chk(16'({half, flow, spd10, thr}), 16'h0801);
    wait_tick;
    wait_tick;
    chk(16'(n), 16'd50);
    @(negedge clk);
    blk = 3'h1;
    @(negedge clk);
    chk(16'(lim), 16'h0);
    @(negedge clk);
    blk = 3'h0;
    chk(16'(lim), 16'h1);
    wait_tick;
    @(negedge clk);
    chk(16'(lim), 16'h0);
    wr(8'h06, 8'h00);
    wait_tick;
    wait_tick;
    chk(16'(n), 16'd20);
    wr(8'h0b, 8'h41);
    chk(16'({pwr, sl, tpid, tmode}), 16'ha);
    rd(8'h0b, 8'h41);
    chk(16'({ind2, ind1, ind0}), 16'h1dd);
    reset(5'h09);
    col = 3'h4;
    lnk = 3'h6;
    act = 3'h1;
    rd(8'h06, 8'h20);
    rd(8'h0b, 8'h08);
    rd(8'h0d, 8'h00);
    chk(16'({sh, ind2, ind1, ind0}), 16'h277);
    print_verdict;
  end
endmodule
`default_nettype wire
